// *** shared/sync_pin_defines.svh ***
// Contract
// - Calibration mode 00 never starts or runs oscillator calibration.
// - Mode 01 calibrates once on power-on rise or sync-missing fall, when idle.
// - Mode 10 calibrates continuously while idle and sync-missing is clear.
// - Sync source bit 2 picks external pin (0) or software strobe (1).
// - Pin choice bit 1 picks sync/general pin (0) or interrupt pin (1).
// - Sync polarity bit 0 inverts the selected sync input before triggering.
// - Pin register bit 6 inverts the interrupt pin output.
// - Pin register bit 5 makes the interrupt pin an input.
// - Read-only pin register bit 4 returns the interrupt pin level.
// - Pin register bit 3 inverts the sync/general pin output.
// - Pin register bit 2 makes the sync/general pin an input.
// - Pin register bit 1 drives sync/general pin low (0) or releases it; resets 1.
// - Read-only pin register bit 0 returns the sync/general pin level.
// - With software source, writing strobe bit 0 at 0xF6 is one trigger.
// - Interval between triggers is counted in 16 bits of 1.3888 us units.
`ifndef SYNC_PIN_DEFINES_SVH
`define SYNC_PIN_DEFINES_SVH

`define PERIOD_LO_ADDR     8'hF2
`define PERIOD_HI_ADDR     8'hF3
`define SYNC_CTRL_ADDR     8'hF6
`define SYNC_CFG_ADDR      8'hF7
`define PIN_CTRL_ADDR      8'hF8

`define CTRL_HOLD_BIT      1
`define CTRL_STROBE_BIT    0

`define CFG_MODE_HI        7
`define CFG_MODE_LO        6
`define CFG_SRC_BIT        2
`define CFG_PINSEL_BIT     1
`define CFG_INV_BIT        0

`define PIN_IRQ_INV_BIT    6
`define PIN_IRQ_INEN_BIT   5
`define PIN_IRQ_IN_BIT     4
`define PIN_AUX_INV_BIT    3
`define PIN_AUX_INEN_BIT   2
`define PIN_AUX_OUT_BIT    1
`define PIN_AUX_IN_BIT     0

`define AUX_OUT_RESET      1'b1

// Period unit and clock in picoseconds; unit count rounds up to whole cycles
`define TICK_PS            1388800
`define CLK_PS             25000
`define TICK_CYCLES        ((`TICK_PS + `CLK_PS - 1) / `CLK_PS)

`endif

// *** shared/sync_pin_pkg.sv ***
package sync_pin_pkg;

    typedef enum logic [1:0] {
        CAL_OFF  = 2'b00,
        CAL_ONCE = 2'b01,
        CAL_CONT = 2'b10,
        CAL_RSVD = 2'b11
    } calib_mode_t;

    typedef struct packed {
        calib_mode_t mode;
        logic        soft_src;
        logic        int_pin_sel;
        logic        invert;
    } sync_cfg_t;

    typedef struct packed {
        logic irq_inv;
        logic irq_in_en;
        logic aux_inv;
        logic aux_in_en;
        logic aux_out;
    } pin_cfg_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic pulse;
    } edge_state_t;

    typedef struct packed {
        sync_cfg_t   cfg;
        pin_cfg_t    pins;
        logic        hold;
        logic        strobe;
        logic        soft_trig;
        logic [7:0]  prescale;
        logic [15:0] count;
        logic [15:0] period;
        logic        locked;
        logic        pend;
        logic        pon_d;
        logic        miss_d;
        logic        cal_start;
        logic        cal_run;
        logic [7:0]  rdata;
    } core_state_t;

endpackage : sync_pin_pkg

// *** hdl/sync_edge_detect.sv ***
`timescale 1ns/1ps
module sync_edge_detect (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Raw pin and polarity
    input  wire logic pin_raw,
    input  wire logic invert,
    // Active edge pulse
    output logic      edge_pulse
);
    sync_pin_pkg::edge_state_t st_r;
    sync_pin_pkg::edge_state_t st_nxt;
    logic                      level;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = pin_raw;
        st_nxt.sync2 = st_r.sync1;
        level        = st_r.sync2 ^ invert;
        st_nxt.prev  = level;
        st_nxt.pulse = level & ~st_r.prev;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Idle level of a pulled-up pin, so the release of reset shows no false edge
            st_r <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, pulse: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign edge_pulse = st_r.pulse;
endmodule : sync_edge_detect

// *** hdl/frame_sync_trigger_pin_ctrl.sv ***
`timescale 1ns/1ps
`include "sync_pin_defines.svh"
module frame_sync_trigger_pin_ctrl #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register port from the serial front end
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Interrupt pin, open drain
    input  wire logic        irq_pin_i,
    output logic             irq_pin_o,
    output logic             irq_pin_oe_n,
    // Sync / general pin, open drain
    input  wire logic        aux_pin_i,
    output logic             aux_pin_o,
    output logic             aux_pin_oe_n,
    // Internal device status
    input  wire logic        irq_src,
    input  wire logic        power_on_bit,
    input  wire logic        sync_missing,
    input  wire logic        meas_active,
    // Oscillator calibration side
    output logic             osc_calib_start,
    output logic             osc_calib_run,
    output logic             sync_trigger,
    output logic      [15:0] sync_period
);
    sync_pin_pkg::core_state_t st_r;
    sync_pin_pkg::core_state_t st_nxt;

    logic ext_raw;
    logic ext_edge;
    logic trig;
    logic irq_level;
    logic aux_level;
    logic tick;
    logic pon_rise;
    logic miss_fall;
    logic once_evt;
    logic idle;

    // Pin choice ahead of the synchroniser; a select change may look like one edge
    assign ext_raw = st_r.cfg.int_pin_sel ? irq_pin_i : aux_pin_i;


    // One synchroniser serves both pins; only the selected one is watched
    sync_edge_detect u_edge (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .pin_raw    (ext_raw),
        .invert     (st_r.cfg.invert),
        .edge_pulse (ext_edge)
    );

    assign trig = st_r.cfg.soft_src ? st_r.soft_trig : ext_edge;

    assign irq_level    = irq_src ^ st_r.pins.irq_inv;
    assign aux_level    = st_r.pins.aux_out ^ st_r.pins.aux_inv;
    assign irq_pin_o    = 1'b0;
    assign aux_pin_o    = 1'b0;
    // Open drain: only ever pull low, never drive high
    assign irq_pin_oe_n = st_r.pins.irq_in_en | irq_level;
    assign aux_pin_oe_n = st_r.pins.aux_in_en | aux_level;


    // Prescaler turns system clocks into fixed period units
    assign tick     = (st_r.prescale == 8'(TICK_CYCLES - 1));
    assign idle     = ~meas_active;

    // Level inputs are compared with last cycle's sample; reset clears both history bits
    assign pon_rise  = power_on_bit & ~st_r.pon_d;
    assign miss_fall = ~sync_missing & st_r.miss_d;
    assign once_evt  = pon_rise | miss_fall;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.soft_trig = 1'b0;
        st_nxt.cal_start = 1'b0;
        st_nxt.pon_d     = power_on_bit;
        st_nxt.miss_d    = sync_missing;

        // Register writes; reserved bits are simply not stored
        if (reg_wr) begin
            if (reg_addr == `SYNC_CTRL_ADDR) begin
                // Strobe is kept for readback; the trigger itself lasts one cycle
                st_nxt.hold      = reg_wdata[`CTRL_HOLD_BIT];
                st_nxt.strobe    = reg_wdata[`CTRL_STROBE_BIT];
                st_nxt.soft_trig = reg_wdata[`CTRL_STROBE_BIT];
            end else if (reg_addr == `SYNC_CFG_ADDR) begin
                st_nxt.cfg.mode        = sync_pin_pkg::calib_mode_t'(
                                         reg_wdata[`CFG_MODE_HI:`CFG_MODE_LO]);
                st_nxt.cfg.soft_src    = reg_wdata[`CFG_SRC_BIT];
                st_nxt.cfg.int_pin_sel = reg_wdata[`CFG_PINSEL_BIT];
                st_nxt.cfg.invert      = reg_wdata[`CFG_INV_BIT];
            end else if (reg_addr == `PIN_CTRL_ADDR) begin
                st_nxt.pins.irq_inv   = reg_wdata[`PIN_IRQ_INV_BIT];
                st_nxt.pins.irq_in_en = reg_wdata[`PIN_IRQ_INEN_BIT];
                st_nxt.pins.aux_inv   = reg_wdata[`PIN_AUX_INV_BIT];
                st_nxt.pins.aux_in_en = reg_wdata[`PIN_AUX_INEN_BIT];
                st_nxt.pins.aux_out   = reg_wdata[`PIN_AUX_OUT_BIT];
            end
        end

        // Read data, registered; unmapped and reserved bits read zero
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `PERIOD_LO_ADDR) begin
                st_nxt.rdata = st_r.period[7:0];
            end else if (reg_addr == `PERIOD_HI_ADDR) begin
                st_nxt.rdata  = st_r.period[15:8];
                st_nxt.locked = 1'b0;
            end else if (reg_addr == `SYNC_CTRL_ADDR) begin
                st_nxt.rdata[`CTRL_HOLD_BIT]   = st_r.hold;
                st_nxt.rdata[`CTRL_STROBE_BIT] = st_r.strobe;
            end else if (reg_addr == `SYNC_CFG_ADDR) begin
                st_nxt.rdata[`CFG_MODE_HI:`CFG_MODE_LO] = st_r.cfg.mode;
                st_nxt.rdata[`CFG_SRC_BIT]    = st_r.cfg.soft_src;
                st_nxt.rdata[`CFG_PINSEL_BIT] = st_r.cfg.int_pin_sel;
                st_nxt.rdata[`CFG_INV_BIT]    = st_r.cfg.invert;
            end else if (reg_addr == `PIN_CTRL_ADDR) begin
                st_nxt.rdata[`PIN_IRQ_INV_BIT]  = st_r.pins.irq_inv;
                st_nxt.rdata[`PIN_IRQ_INEN_BIT] = st_r.pins.irq_in_en;
                st_nxt.rdata[`PIN_IRQ_IN_BIT]   = irq_pin_i;
                st_nxt.rdata[`PIN_AUX_INV_BIT]  = st_r.pins.aux_inv;
                st_nxt.rdata[`PIN_AUX_INEN_BIT] = st_r.pins.aux_in_en;
                st_nxt.rdata[`PIN_AUX_OUT_BIT]  = st_r.pins.aux_out;
                st_nxt.rdata[`PIN_AUX_IN_BIT]   = aux_pin_i;
            end
        end

        // Interval count in fixed time units, saturating so a lost sync never wraps
        st_nxt.prescale = tick ? 8'h00 : st_r.prescale + 8'h01;
        if (tick && st_r.count != 16'hFFFF) begin
            st_nxt.count = st_r.count + 16'h0001;
        end
        // Hold keeps the latched pair coherent while software reads it byte by byte
        if (trig) begin
            st_nxt.count    = 16'h0000;
            st_nxt.prescale = 8'h00;
            if (!st_r.locked) begin
                st_nxt.period = st_r.count;
                st_nxt.locked = st_r.hold;
            end
        end

        // Calibration control
        st_nxt.cal_run = 1'b0;
        case (st_r.cfg.mode)
            sync_pin_pkg::CAL_OFF: begin
                st_nxt.pend = 1'b0;
            end
            sync_pin_pkg::CAL_ONCE: begin
                // An event seen during a measurement waits until it ends
                if ((once_evt || st_r.pend) && idle) begin
                    st_nxt.cal_start = 1'b1;
                    st_nxt.pend      = 1'b0;
                end else if (once_evt) begin
                    st_nxt.pend = 1'b1;
                end
            end
            sync_pin_pkg::CAL_CONT: begin
                st_nxt.pend    = 1'b0;
                st_nxt.cal_run = idle & ~sync_missing;
            end
            default: begin
                // Reserved mode is stored as written and acts as off
                st_nxt.pend = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r.cfg            <= '0;
            st_r.pins.irq_inv   <= 1'b0;
            st_r.pins.irq_in_en <= 1'b0;
            st_r.pins.aux_inv   <= 1'b0;
            st_r.pins.aux_in_en <= 1'b0;
            // Released by default so no current flows through the pull-up
            st_r.pins.aux_out   <= `AUX_OUT_RESET;
            st_r.hold           <= 1'b0;
            st_r.strobe         <= 1'b0;
            st_r.soft_trig      <= 1'b0;
            st_r.prescale       <= 8'h00;
            st_r.count          <= 16'h0000;
            st_r.period         <= 16'h0000;
            st_r.locked         <= 1'b0;
            st_r.pend           <= 1'b0;
            st_r.pon_d          <= 1'b0;
            st_r.miss_d         <= 1'b0;
            st_r.cal_start      <= 1'b0;
            st_r.cal_run        <= 1'b0;
            st_r.rdata          <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata       = st_r.rdata;
    assign osc_calib_start = st_r.cal_start;
    assign osc_calib_run   = st_r.cal_run;
    assign sync_trigger    = trig;
    assign sync_period     = st_r.period;
endmodule : frame_sync_trigger_pin_ctrl

// *** bench/frame_sync_trigger_pin_ctrl_props.sv ***
`timescale 1ns/1ps
module fs_pin_checker (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic       irq_pin_i,
    input wire logic       irq_pin_o,
    input wire logic       irq_pin_oe_n,
    input wire logic       aux_pin_i,
    input wire logic       aux_pin_o,
    input wire logic       aux_pin_oe_n,
    // Status and calibration
    input wire logic       irq_src,
    input wire logic       power_on_bit,
    input wire logic       sync_missing,
    input wire logic       meas_active,
    input wire logic       osc_calib_start,
    input wire logic       osc_calib_run,
    input wire logic       sync_trigger
);
    logic [7:0] cfg_r;
    logic [4:0] pin_r;
    logic       sel_in;

    // Shadow copies of the two config registers, reserved bits dropped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_r <= 8'h00;
            pin_r <= 5'h01;
        end else if (reg_wr && reg_addr == 8'hF7) begin
            cfg_r <= reg_wdata & 8'hC7;
        end else if (reg_wr && reg_addr == 8'hF8) begin
            pin_r <= {reg_wdata[6:5], reg_wdata[3:1]};
        end
    end
    assign sel_in = (cfg_r[1] ? irq_pin_i : aux_pin_i) ^ cfg_r[0];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_mode_off: assert property (cfg_r[7] == cfg_r[6] && $past(cfg_r[7]) == $past(cfg_r[6])
        |-> !osc_calib_start && !osc_calib_run) else $error("calibration while off");
    a_once_start: assert property (cfg_r[7:6] == 2'b01 && !meas_active
        && ($rose(power_on_bit) || $fell(sync_missing)) |=> osc_calib_start)
        else $error("single calibration missing");
    a_cont_run: assert property (cfg_r[7:6] == 2'b10
        |=> osc_calib_run == !($past(meas_active) || $past(sync_missing)))
        else $error("continuous calibration wrong");
    a_soft_trig: assert property (reg_wr && reg_addr == 8'hF6 && reg_wdata[0] && cfg_r[2]
        |=> sync_trigger) else $error("soft strobe gave no trigger");
    a_ext_trig: assert property ($stable(cfg_r) && !cfg_r[2] && $rose(sel_in)
        ##1 $stable(cfg_r) [*3] |-> sync_trigger) else $error("pin edge gave no trigger");
    a_irq_drive: assert property (irq_pin_o == 1'b0
        && irq_pin_oe_n == (pin_r[3] | (irq_src ^ pin_r[4]))) else $error("irq pin drive");
    a_aux_drive: assert property (aux_pin_o == 1'b0
        && aux_pin_oe_n == (pin_r[1] | (pin_r[0] ^ pin_r[2]))) else $error("aux pin drive");
    a_pin_read: assert property (reg_rd && reg_addr == 8'hF8 |=> reg_rdata ==
        {1'b0, $past(pin_r[4:3]), $past(irq_pin_i), $past(pin_r[2:0]), $past(aux_pin_i)})
        else $error("pin register readback");
    a_cfg_read: assert property (reg_rd && reg_addr == 8'hF7
        |=> reg_rdata == $past(cfg_r)) else $error("config readback");
endmodule : fs_pin_checker

bind frame_sync_trigger_pin_ctrl fs_pin_checker fs_pin_checker_inst (.sys_clk, .rst,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .irq_pin_i, .irq_pin_o,
    .irq_pin_oe_n, .aux_pin_i, .aux_pin_o, .aux_pin_oe_n, .irq_src, .power_on_bit,
    .sync_missing, .meas_active, .osc_calib_start, .osc_calib_run, .sync_trigger);

// *** bench/sync_frame_partner.sv ***
`timescale 1ns/1ps
module sync_frame_partner (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Frame command from the bench
    input wire logic       fire,
    input wire logic       use_irq,
    input wire logic [3:0] width,
    input wire logic       host_irq_lo,
    // Open-drain nets
    input wire logic       irq_oe_n,
    input wire logic       aux_oe_n,
    output logic           irq_net,
    output logic           aux_net
);
    logic [3:0] left_r;

    // Active-low frame pulse, width chosen per frame so slow and prompt both occur
    always_ff @(posedge sys_clk) begin
        if (rst) left_r <= 4'h0;
        else if (fire) left_r <= width;
        else if (left_r != 4'h0) left_r <= left_r - 4'h1;
    end
    // Both nets carry pull-ups, so a released net reads high, never floats
    assign aux_net = aux_oe_n & !(left_r != 4'h0 && !use_irq);
    assign irq_net = irq_oe_n & !host_irq_lo & !(left_r != 4'h0 && use_irq);
endmodule : sync_frame_partner

// *** bench/test_frame_sync_trigger_pin_ctrl.sv ***
`timescale 1ns/1ps
module test_frame_sync_trigger_pin_ctrl;
    localparam int TICK = 4;
    logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq_src = 0, power_on_bit = 0;
    logic sync_missing = 0, meas_active = 0, fire = 0, use_irq = 0, host_lo = 0;
    logic irq_pin_o, irq_pin_oe_n, aux_pin_o, aux_pin_oe_n, irq_net, aux_net;
    logic osc_calib_start, osc_calib_run, sync_trigger;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, v;
    logic [3:0] width = 4'h3;
    logic [15:0] sync_period, p;
    logic [31:0] r;
    int fails = 0, tests_run = 0, seed = 32'h09d2761b, trig_n = 0, st_n = 0, run_n = 0;
    int s0, r0;

    frame_sync_trigger_pin_ctrl #(.TICK_CYCLES(TICK)) frame_sync_trigger_pin_ctrl_inst (
        .sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .irq_pin_i(irq_net), .irq_pin_o, .irq_pin_oe_n, .aux_pin_i(aux_net), .aux_pin_o,
        .aux_pin_oe_n, .irq_src, .power_on_bit, .sync_missing, .meas_active,
        .osc_calib_start, .osc_calib_run, .sync_trigger, .sync_period);
    sync_frame_partner sync_frame_partner_inst (.sys_clk, .rst, .fire, .use_irq, .width,
        .host_irq_lo(host_lo), .irq_oe_n(irq_pin_oe_n), .aux_oe_n(aux_pin_oe_n),
        .irq_net, .aux_net);

    always #12.5 sys_clk = ~sys_clk;
    // Sampled mid-cycle, where registered outputs have settled
    always @(negedge sys_clk) begin
        if (!rst) begin
            trig_n += sync_trigger;
            st_n += osc_calib_start;
            run_n += osc_calib_run;
        end
    end

    task stop_test;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Pin register image with the net levels that open drain and pull-ups give
    function automatic logic [7:0] exp_pins(input logic [7:0] w);
        logic il;
        il = (w[5] | (irq_src ^ w[6])) & !host_lo;
        return {1'b0, w[6:5], il, w[3:1], w[2] | (w[1] ^ w[3])};
    endfunction : exp_pins

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        $display("[ERR] %0t run did not finish", $time);
        stop_test();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'hF7); chk(d, 8'h00);
        rd(8'hF8); chk(d, exp_pins(8'h02));
        @(posedge sys_clk);
        #1 chk(reg_rdata, 8'h00);
        rd(8'h55); chk(d, 8'h00);
        repeat (24) begin
            r = $random(seed);
            v = r[7:0];
            @(posedge sys_clk);
            irq_src <= r[8];
            host_lo <= r[9];
            wr(8'hF8, v);
            rd(8'hF8); chk(d, exp_pins(v));
            v = r[23:16] & 8'h7F;
            wr(8'hF7, v);
            rd(8'hF7); chk(d, v & 8'hC7);
        end
        @(posedge sys_clk);
        host_lo <= 1'b0;
        wr(8'hF8, 8'h26);
        for (int m = 0; m < 3; m++) begin
            wr(8'hF7, {m[1:0], 6'h00});
            #1 s0 = st_n;
            r0 = run_n;
            @(posedge sys_clk);
            power_on_bit <= 1'b1;
            repeat (6) @(posedge sys_clk);
            power_on_bit <= 1'b0;
            #1 chk(16'(st_n - s0), 16'(m == 1));
            chk(16'(run_n - r0 > 3), 16'(m == 2));
        end
        wr(8'hF7, 8'h80);
        @(posedge sys_clk);
        sync_missing <= 1'b1;
        meas_active <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 r0 = run_n;
        repeat (4) @(posedge sys_clk);
        #1 chk(16'(run_n - r0), 16'd0);
        wr(8'hF7, 8'h40);
        #1 s0 = st_n;
        @(posedge sys_clk);
        power_on_bit <= 1'b1;
        sync_missing <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 chk(16'(st_n - s0), 16'd0);
        @(posedge sys_clk);
        meas_active <= 1'b0;
        power_on_bit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(st_n - s0), 16'd1);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            use_irq <= k[1];
            wr(8'hF7, {6'h00, k[1:0]});
            repeat (8) @(posedge sys_clk);
            #1 s0 = trig_n;
            repeat (3) begin
                r = $random(seed);
                @(posedge sys_clk);
                width <= 4'h1 + {1'b0, r[2:0]};
                fire <= 1'b1;
                @(posedge sys_clk);
                fire <= 1'b0;
                repeat (20) @(posedge sys_clk);
            end
            #1 chk(16'(trig_n - s0), 16'd3);
        end
        wr(8'hF7, 8'h04);
        #1 s0 = trig_n;
        wr(8'hF6, 8'h01);
        repeat (40) @(posedge sys_clk);
        wr(8'hF6, 8'h01);
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(trig_n - s0), 16'd2);
        rd(8'hF2); p[7:0] = d;
        rd(8'hF3); p[15:8] = d;
        chk(16'(p + 16'd1 - 16'(43 / TICK) <= 16'd2), 16'd1);
        chk(sync_period, p);
        wr(8'hF6, 8'h03);
        repeat (3) @(posedge sys_clk);
        #1 p = sync_period;
        repeat (16) @(posedge sys_clk);
        wr(8'hF6, 8'h03);
        repeat (3) @(posedge sys_clk);
        #1 chk(sync_period, p);
        stop_test();
    end
endmodule : test_frame_sync_trigger_pin_ctrl
